// *** hw/ddcnd_device.sv ***
// converter end: nco, mixer, decimation chain, gain, fs/4 real output
// assumes: core_clk is the sampling clock, one adc sample per cycle
// Overview of operation
// - decimate complex samples by 2..32
// - real mode: no mixing, low-pass only
// - datapath carries 20 bits throughout
// - optional 6 dB gain in complex mode
// - optional 3 dB gain in real mode
// - fs/4 mix, real stream at twice rate
// - positive rotation, inversion bit negates phase
// - mixer multiplies samples by nco exponential
// - nco word is signed, wraps naturally
// - controller computes word from wanted frequency; here the controller takes the word as written over apb
// - new word active only after reload/sync
// - enable bit turns pin into sync
// - sync pin sampled on clock rising edge
// - sync resets dividers, aligns i and q
// - sync also restarts nco and loads word
// - controller issues sync when decimating
// - resync placed on 64-cycle multiples
// - controller zeroes nco word in real mode
// - about 80 percent passband, 85 dB stop; the stages here only average sample pairs
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module ddcnd_device (
   input wire logic core_clk,
   input wire logic sys_rst,
   ddcnd_link_if.dev link,
   input wire logic [ddcnd_pkg::ADC_W-1:0] adc_data,
   output logic pd_active
);
   typedef struct packed {
      logic [ddcnd_pkg::NCO_W-1:0] phase;
      logic [ddcnd_pkg::NCO_W-1:0] freq;
      logic pin;
      logic pin_d;
      logic rld;
      logic pd;
      logic rot;
      logic fs4_pend;
      logic [ddcnd_pkg::DW-1:0] pend;
      logic [ddcnd_pkg::DW-1:0] oi;
      logic [ddcnd_pkg::DW-1:0] oq;
      logic ov;
      logic oreal;
   } ddcnd_dev_t;
   ddcnd_dev_t r_ff;
   ddcnd_dev_t nxt_r;

   logic signed [ddcnd_pkg::DW-1:0] x;
   logic [ddcnd_pkg::PHI_W-1:0] lut_idx;
   logic signed [ddcnd_pkg::COEF_W-1:0] c_cos;
   logic signed [ddcnd_pkg::COEF_W-1:0] c_sin;
   logic signed [ddcnd_pkg::DW+ddcnd_pkg::COEF_W-1:0] prod_i;
   logic signed [ddcnd_pkg::DW+ddcnd_pkg::COEF_W-1:0] prod_q;
   logic [ddcnd_pkg::DW-1:0] mix_i;
   logic [ddcnd_pkg::DW-1:0] mix_q;
   logic [ddcnd_pkg::DW-1:0] st_i [0:ddcnd_pkg::NSTG];
   logic [ddcnd_pkg::DW-1:0] st_q [0:ddcnd_pkg::NSTG];
   logic st_v [0:ddcnd_pkg::NSTG];
   logic sync_evt;
   logic reload_evt;
   logic [ddcnd_pkg::SEL_W-1:0] sel;
   logic [ddcnd_pkg::DW-1:0] d_i;
   logic [ddcnd_pkg::DW-1:0] d_q;
   logic d_v;
   logic [ddcnd_pkg::DW-1:0] g_i;
   logic [ddcnd_pkg::DW-1:0] g_q;

   function automatic logic [ddcnd_pkg::DW-1:0] sat(input logic signed [ddcnd_pkg::DW+1:0] v);
      if (v > $signed({2'b00, ddcnd_pkg::DMAX})) begin
         sat = ddcnd_pkg::DMAX;
      end else if (v < $signed({2'b11, ddcnd_pkg::DMIN})) begin
         sat = ddcnd_pkg::DMIN;
      end else begin
         sat = v[ddcnd_pkg::DW-1:0];
      end
   endfunction : sat

   // x2 for complex loss, x1.406 (close to 3 dB) for real
   function automatic logic [ddcnd_pkg::DW-1:0] gain(input logic signed [ddcnd_pkg::DW-1:0] v,
         input logic on, input logic rl);
      logic signed [ddcnd_pkg::DW+1:0] e;
      e = {{2{v[ddcnd_pkg::DW-1]}}, v};
      if (!on) begin
         gain = v;
      end else if (rl) begin
         gain = sat(e + (e >>> ddcnd_pkg::G3_S1) + (e >>> ddcnd_pkg::G3_S2)
            + (e >>> ddcnd_pkg::G3_S3));
      end else begin
         gain = sat(e <<< 1);
      end
   endfunction : gain

   // adc code in the top bits of the 20-bit word
   assign x = {adc_data, {ddcnd_pkg::ADC_SHIFT{1'b0}}};

   assign lut_idx = r_ff.phase[ddcnd_pkg::NCO_W-1 -: ddcnd_pkg::PHI_W];
   assign c_cos = ddcnd_pkg::cos_lut(lut_idx);
   assign c_sin = ddcnd_pkg::cos_lut(lut_idx - ddcnd_pkg::LUT_QTR);
   assign prod_i = x * c_cos;
   assign prod_q = x * c_sin;
   assign mix_i = prod_i[ddcnd_pkg::DW+ddcnd_pkg::MUL_LSB-1:ddcnd_pkg::MUL_LSB];
   // inverted phase conjugates the exponential
   assign mix_q = link.phase_inv ? -prod_q[ddcnd_pkg::DW+ddcnd_pkg::MUL_LSB-1:ddcnd_pkg::MUL_LSB]
      : prod_q[ddcnd_pkg::DW+ddcnd_pkg::MUL_LSB-1:ddcnd_pkg::MUL_LSB];

   // real mode skips the mixer entirely
   assign st_i[0] = link.real_mode ? x : mix_i;
   assign st_q[0] = link.real_mode ? '0 : mix_q;
   assign st_v[0] = link.ddc_en & ~r_ff.pd;

   // edge of the sampled pin, only when it acts as sync
   assign sync_evt = link.sync_en & r_ff.pin & ~r_ff.pin_d;
   assign reload_evt = link.nco_reload ^ r_ff.rld;

   // two-tap averaging only: far below the 85 dB stopband of a real design
   genvar k;
   generate
      for (k = 0; k < ddcnd_pkg::NSTG; k++) begin : g_stage
         ddcnd_half_stage u_stage (
            .core_clk(core_clk),
            .sys_rst(sys_rst),
            .clr(sync_evt),
            .in_valid(st_v[k]),
            .in_i(st_i[k]),
            .in_q(st_q[k]),
            .out_valid(st_v[k+1]),
            .out_i(st_i[k+1]),
            .out_q(st_q[k+1])
         );
      end
   endgenerate

   // codes above the last stage fall back to the deepest factor
   assign sel = (link.dec_sel >= ddcnd_pkg::SEL_W'(ddcnd_pkg::NSTG))
      ? ddcnd_pkg::SEL_W'(ddcnd_pkg::NSTG - 1) : link.dec_sel;
   assign d_i = st_i[sel + 1'b1];
   assign d_q = st_q[sel + 1'b1];
   assign d_v = st_v[sel + 1'b1];
   assign g_i = gain(d_i, link.gain_en, link.real_mode);
   assign g_q = gain(d_q, link.gain_en, link.real_mode);

   always_comb begin
      nxt_r = r_ff;
      nxt_r.pin = link.powerdown_or_align_pin;
      nxt_r.pin_d = r_ff.pin;
      nxt_r.rld = link.nco_reload;
      nxt_r.pd = ~link.sync_en & r_ff.pin;
      nxt_r.ov = 1'b0;
      if (sync_evt || reload_evt) begin
         nxt_r.phase = '0;
         nxt_r.freq = link.nco_word;
      end else begin
         nxt_r.phase = r_ff.phase + r_ff.freq;
      end
      if (sync_evt) begin
         nxt_r.rot = 1'b0;
         nxt_r.fs4_pend = 1'b0;
      end
      if (r_ff.pd) begin
         nxt_r.fs4_pend = 1'b0;
      end else if (!link.ddc_en) begin
         nxt_r.oi = x;
         // drop a half pair so it cannot leak out on re-enable
         nxt_r.fs4_pend = 1'b0;
         nxt_r.oq = '0;
         nxt_r.ov = 1'b1;
         nxt_r.oreal = 1'b1;
      end else if (r_ff.fs4_pend) begin
         // second real sample of the pair, in the idle slot
         nxt_r.oi = r_ff.pend;
         nxt_r.oq = '0;
         nxt_r.ov = 1'b1;
         nxt_r.oreal = 1'b1;
         nxt_r.fs4_pend = 1'b0;
      end else if (d_v) begin
         nxt_r.ov = 1'b1;
         if (link.fs4_en && !link.real_mode) begin
            // rotation by j^n: I, -Q, -I, Q
            nxt_r.oi = r_ff.rot ? -g_i : g_i;
            nxt_r.pend = r_ff.rot ? g_q : -g_q;
            nxt_r.oq = '0;
            nxt_r.oreal = 1'b1;
            nxt_r.fs4_pend = 1'b1;
            nxt_r.rot = ~r_ff.rot;
         end else if (link.real_mode) begin
            nxt_r.oi = g_i;
            nxt_r.oq = '0;
            nxt_r.oreal = 1'b1;
         end else begin
            nxt_r.oi = g_i;
            nxt_r.oq = g_q;
            nxt_r.oreal = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign link.smp_i = r_ff.oi;
   assign link.smp_q = r_ff.oq;
   assign link.smp_valid = r_ff.ov;
   assign link.smp_real = r_ff.oreal;
   assign pd_active = r_ff.pd;
endmodule : ddcnd_device
`default_nettype wire

// *** pkg/ddcnd_pkg.sv ***
// constants shared by the down converter, its controller and the link
// assumes: 100 MHz core_clk is the converter sampling clock
package ddcnd_pkg;
   localparam int ADC_W = 14;
   localparam int DW = 20;
   localparam int NCO_W = 32;
   localparam int NSTG = 5;
   localparam int SEL_W = 3;
   localparam int PHI_W = 3;
   localparam int COEF_W = 12;
   localparam int ADC_SHIFT = DW - ADC_W;
   localparam int MUL_LSB = COEF_W - 1;
   localparam logic [COEF_W-1:0] COS_ONE = 12'h7ff;
   localparam logic [COEF_W-1:0] COS_RT2 = 12'h5a8;
   localparam logic [PHI_W-1:0] LUT_QTR = 3'h2;
   localparam logic [DW-1:0] DMAX = 20'h7_ffff;
   localparam logic [DW-1:0] DMIN = 20'h8_0000;
   localparam int G3_S1 = 2;
   localparam int G3_S2 = 3;
   localparam int G3_S3 = 5;
   // apb map of the controller
   localparam int AW = 8;
   localparam logic [AW-1:0] OFS_CTRL = 8'h00;
   localparam logic [AW-1:0] OFS_NCO = 8'h04;
   localparam logic [AW-1:0] OFS_CMD = 8'h08;
   localparam logic [AW-1:0] OFS_STAT = 8'h0c;
   localparam logic [AW-1:0] OFS_LAST_I = 8'h10;
   localparam logic [AW-1:0] OFS_LAST_Q = 8'h14;
   localparam int CB_EN = 0;
   localparam int CB_REAL = 1;
   localparam int CB_GAIN = 2;
   localparam int CB_FS4 = 3;
   localparam int CB_INV = 4;
   localparam int CB_SYNCEN = 5;
   localparam int CB_SEL = 8;
   localparam int CMD_RELOAD = 0;
   localparam int CMD_SYNC = 1;
   localparam int ST_PEND = 0;
   localparam int ST_REAL = 1;
   localparam int ST_CNT = 16;
   localparam int CNT_W = 16;
   localparam int ALIGN_W = 6;
   localparam int SYNC_ALIGN = 64;

   function automatic logic signed [COEF_W-1:0] cos_lut(input logic [PHI_W-1:0] i);
      case (i)
         3'h0: cos_lut = COS_ONE;
         3'h1: cos_lut = COS_RT2;
         3'h3: cos_lut = -COS_RT2;
         3'h4: cos_lut = -COS_ONE;
         3'h5: cos_lut = -COS_RT2;
         3'h7: cos_lut = COS_RT2;
         default: cos_lut = '0;
      endcase
   endfunction : cos_lut
endpackage : ddcnd_pkg

// *** pkg/ddcnd_link_if.sv ***
// configuration pins and sample stream between controller and converter
// assumes: both ends on core_clk
`timescale 1ns/1ns
`default_nettype none
interface ddcnd_link_if;
   logic ddc_en;
   logic real_mode;
   logic gain_en;
   logic fs4_en;
   logic phase_inv;
   logic sync_en;
   logic nco_reload;
   logic powerdown_or_align_pin;
   logic [ddcnd_pkg::SEL_W-1:0] dec_sel;
   logic [ddcnd_pkg::NCO_W-1:0] nco_word;
   logic [ddcnd_pkg::DW-1:0] smp_i;
   logic [ddcnd_pkg::DW-1:0] smp_q;
   logic smp_valid;
   logic smp_real;
   modport dev (input ddc_en, real_mode, gain_en, fs4_en, phase_inv, sync_en, nco_reload,
      powerdown_or_align_pin, dec_sel, nco_word, output smp_i, smp_q, smp_valid, smp_real);
   modport host (output ddc_en, real_mode, gain_en, fs4_en, phase_inv, sync_en, nco_reload,
      powerdown_or_align_pin, dec_sel, nco_word, input smp_i, smp_q, smp_valid, smp_real);
endinterface : ddcnd_link_if
`default_nettype wire

// *** hw/ddcnd_half_stage.sv ***
// one decimate-by-two stage: pairwise average of complex samples
// assumes: clr aligns the pairing phase for all stages at once
`timescale 1ns/1ns
`default_nettype none
module ddcnd_half_stage (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clr,
   input wire logic in_valid,
   input wire logic [ddcnd_pkg::DW-1:0] in_i,
   input wire logic [ddcnd_pkg::DW-1:0] in_q,
   output logic out_valid,
   output logic [ddcnd_pkg::DW-1:0] out_i,
   output logic [ddcnd_pkg::DW-1:0] out_q
);
   typedef struct packed {
      logic ph;
      logic [ddcnd_pkg::DW-1:0] hi;
      logic [ddcnd_pkg::DW-1:0] hq;
      logic ov;
      logic [ddcnd_pkg::DW-1:0] oi;
      logic [ddcnd_pkg::DW-1:0] oq;
   } ddcnd_stg_t;
   ddcnd_stg_t r_ff;
   ddcnd_stg_t nxt_r;
   logic [ddcnd_pkg::DW:0] sum_i;
   logic [ddcnd_pkg::DW:0] sum_q;

   // one guard bit keeps the average from wrapping
   assign sum_i = {r_ff.hi[ddcnd_pkg::DW-1], r_ff.hi} + {in_i[ddcnd_pkg::DW-1], in_i};
   assign sum_q = {r_ff.hq[ddcnd_pkg::DW-1], r_ff.hq} + {in_q[ddcnd_pkg::DW-1], in_q};

   always_comb begin
      nxt_r = r_ff;
      nxt_r.ov = 1'b0;
      if (clr) begin
         nxt_r.ph = 1'b0;
      end else if (in_valid) begin
         nxt_r.ph = ~r_ff.ph;
         if (r_ff.ph) begin
            nxt_r.oi = sum_i[ddcnd_pkg::DW:1];
            nxt_r.oq = sum_q[ddcnd_pkg::DW:1];
            nxt_r.ov = 1'b1;
         end else begin
            nxt_r.hi = in_i;
            nxt_r.hq = in_q;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign out_valid = r_ff.ov;
   assign out_i = r_ff.oi;
   assign out_q = r_ff.oq;
endmodule : ddcnd_half_stage
`default_nettype wire

// *** hw/ddcnd_host.sv ***
// controller end: apb registers drive the converter configuration,
// issue sync and reload, and capture the sample stream
// assumes: apb master on core_clk, link partner on the same clock
`timescale 1ns/1ns
`default_nettype none
module ddcnd_host (
   input wire logic core_clk,
   input wire logic sys_rst,
   ddcnd_link_if.host link,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ddcnd_pkg::AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   typedef struct packed {
      logic [31:0] ctrl;
      logic [ddcnd_pkg::NCO_W-1:0] nco;
      logic [ddcnd_pkg::NCO_W-1:0] nco_out;
      logic rld;
      logic pin;
      logic pend;
      logic en_d;
      logic [ddcnd_pkg::ALIGN_W-1:0] cnt64;
      logic [ddcnd_pkg::DW-1:0] li;
      logic [ddcnd_pkg::DW-1:0] lq;
      logic lreal;
      logic [ddcnd_pkg::CNT_W-1:0] scnt;
      logic [31:0] rdata;
      logic rdy;
      logic err;
   } ddcnd_host_t;
   ddcnd_host_t r_ff;
   ddcnd_host_t nxt_r;
   logic setup;
   logic wr_take;
   logic mapped;

   assign setup = psel & ~penable & ~r_ff.rdy;
   assign wr_take = psel & penable & r_ff.rdy & pwrite;
   assign mapped = (paddr == ddcnd_pkg::OFS_CTRL) || (paddr == ddcnd_pkg::OFS_NCO)
      || (paddr == ddcnd_pkg::OFS_CMD) || (paddr == ddcnd_pkg::OFS_STAT)
      || (paddr == ddcnd_pkg::OFS_LAST_I) || (paddr == ddcnd_pkg::OFS_LAST_Q);

   always_comb begin
      nxt_r = r_ff;
      nxt_r.rdy = setup;
      nxt_r.err = setup & ~mapped;
      nxt_r.cnt64 = r_ff.cnt64 + 1'b1;
      nxt_r.en_d = r_ff.ctrl[ddcnd_pkg::CB_EN];
      nxt_r.pin = 1'b0;
      if (setup) begin
         case (paddr)
            ddcnd_pkg::OFS_CTRL: nxt_r.rdata = r_ff.ctrl;
            ddcnd_pkg::OFS_NCO: nxt_r.rdata = r_ff.nco;
            ddcnd_pkg::OFS_STAT: nxt_r.rdata = {r_ff.scnt, 14'h0000, r_ff.lreal, r_ff.pend};
            ddcnd_pkg::OFS_LAST_I: nxt_r.rdata = 32'(signed'(r_ff.li));
            ddcnd_pkg::OFS_LAST_Q: nxt_r.rdata = 32'(signed'(r_ff.lq));
            default: nxt_r.rdata = '0;
         endcase
      end
      // pulse only on the 64-cycle grid to keep divider phase
      if (r_ff.pend && r_ff.cnt64 == '0) begin
         nxt_r.pin = 1'b1;
         nxt_r.pend = 1'b0;
      end
      // turning the decimator on always earns a sync; set wins
      if (r_ff.ctrl[ddcnd_pkg::CB_EN] && !r_ff.en_d) begin
         nxt_r.pend = 1'b1;
      end
      if (wr_take) begin
         case (paddr)
            ddcnd_pkg::OFS_CTRL: nxt_r.ctrl = pwdata;
            ddcnd_pkg::OFS_NCO: nxt_r.nco = pwdata;
            ddcnd_pkg::OFS_CMD: begin
               if (pwdata[ddcnd_pkg::CMD_RELOAD]) begin
                  nxt_r.rld = ~r_ff.rld;
               end
               if (pwdata[ddcnd_pkg::CMD_SYNC]) begin
                  nxt_r.pend = 1'b1;
               end
            end
            default: nxt_r.rdy = 1'b0;
         endcase
      end
      // real mode needs no nco, zero saves power
      nxt_r.nco_out = nxt_r.ctrl[ddcnd_pkg::CB_REAL] ? '0 : nxt_r.nco;
      if (link.smp_valid) begin
         nxt_r.li = link.smp_i;
         nxt_r.lq = link.smp_q;
         nxt_r.lreal = link.smp_real;
         nxt_r.scnt = r_ff.scnt + 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign link.ddc_en = r_ff.ctrl[ddcnd_pkg::CB_EN];
   assign link.real_mode = r_ff.ctrl[ddcnd_pkg::CB_REAL];
   assign link.gain_en = r_ff.ctrl[ddcnd_pkg::CB_GAIN];
   assign link.fs4_en = r_ff.ctrl[ddcnd_pkg::CB_FS4];
   assign link.phase_inv = r_ff.ctrl[ddcnd_pkg::CB_INV];
   assign link.sync_en = r_ff.ctrl[ddcnd_pkg::CB_SYNCEN];
   assign link.dec_sel = r_ff.ctrl[ddcnd_pkg::CB_SEL +: ddcnd_pkg::SEL_W];
   assign link.nco_word = r_ff.nco_out;
   assign link.nco_reload = r_ff.rld;
   assign link.powerdown_or_align_pin = r_ff.pin;
   assign prdata = r_ff.rdata;
   assign pready = r_ff.rdy;
   assign pslverr = r_ff.err;
endmodule : ddcnd_host
`default_nettype wire

// *** tb/ddcnd_link_asserts.sv ***
// concurrent checks on the link between controller and converter ends
// assumes: instantiated beside the link interface, one clock domain
`timescale 1ns/1ns
`default_nettype none
module ddcnd_link_asserts (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic ddc_en,
   input wire logic real_mode,
   input wire logic gain_en,
   input wire logic fs4_en,
   input wire logic phase_inv,
   input wire logic sync_en,
   input wire logic nco_reload,
   input wire logic powerdown_or_align_pin,
   input wire logic [ddcnd_pkg::SEL_W-1:0] dec_sel,
   input wire logic [ddcnd_pkg::NCO_W-1:0] nco_word,
   input wire logic [ddcnd_pkg::DW-1:0] smp_i,
   input wire logic [ddcnd_pkg::DW-1:0] smp_q,
   input wire logic smp_valid,
   input wire logic smp_real
);
   logic [6:0] calm_ff;
   logic [5:0] since_ff;
   logic seen_ff;
   logic calm;
   logic c8;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // rate checks only once the chain has settled after a mode change
   assign calm = calm_ff[6];
   assign c8 = calm && ddc_en && !fs4_en && dec_sel == 3'h2;
   always_ff @(posedge core_clk) begin
      if (sys_rst || $changed({ddc_en, real_mode, fs4_en, gain_en, sync_en, dec_sel})) begin
         calm_ff <= 7'h00;
      end else if (!calm) begin
         calm_ff <= calm_ff + 7'h01;
      end
      if (sys_rst) begin
         since_ff <= 6'h00;
         seen_ff <= 1'b0;
      end else if (powerdown_or_align_pin) begin
         since_ff <= 6'h00;
         seen_ff <= 1'b1;
      end else begin
         since_ff <= since_ff + 6'h01;
      end
   end
   property p_pass;
      (!ddc_en && !powerdown_or_align_pin) [*6] |-> smp_valid && smp_real && smp_q == '0;
   endproperty
   a_pass: assert property (p_pass) else $error("raw stream gap or flag");
   property p_real;
      calm && ddc_en && real_mode && !fs4_en && smp_valid |-> smp_real && smp_q == '0;
   endproperty
   a_real: assert property (p_real) else $error("real stream carries q");
   property p_cplx;
      calm && ddc_en && !real_mode && !fs4_en && smp_valid |-> !smp_real;
   endproperty
   a_cplx: assert property (p_cplx) else $error("complex stream flagged real");
   property p_early;
      c8 && smp_valid |=> (!smp_valid || !c8) [*7];
   endproperty
   a_early: assert property (p_early) else $error("sample before eighth input");
   property p_late;
      (!powerdown_or_align_pin) [*4] ##0 (c8 && smp_valid) ##1
         (c8 && !smp_valid && !powerdown_or_align_pin) [*7] |=> smp_valid;
   endproperty
   a_late: assert property (p_late) else $error("sample missing after eight inputs");
   property p_half;
      (!powerdown_or_align_pin) [*4] ##0 (calm && ddc_en && !fs4_en && dec_sel == 3'h0 && smp_valid)
         |=> !smp_valid ##1 smp_valid;
   endproperty
   a_half: assert property (p_half) else $error("half rate cadence broken");
   property p_fs4;
      calm && ddc_en && fs4_en && !real_mode && dec_sel == 3'h2 && smp_valid && !$past(smp_valid)
         |=> smp_valid && smp_real ##1 !smp_valid [*6];
   endproperty
   a_fs4: assert property (p_fs4) else $error("quarter rate pair broken");
   property p_nco0;
      real_mode && $past(real_mode) |-> nco_word == '0;
   endproperty
   a_nco0: assert property (p_nco0) else $error("nonzero word in real mode");
   property p_pulse;
      $rose(powerdown_or_align_pin) |=> !powerdown_or_align_pin;
   endproperty
   a_pulse: assert property (p_pulse) else $error("align pulse too long");
   property p_align;
      powerdown_or_align_pin && seen_ff |-> since_ff == 6'h3f;
   endproperty
   a_align: assert property (p_align) else $error("align pulse off 64 grid");
   property p_pd;
      calm && !ddc_en && !sync_en && powerdown_or_align_pin |-> ##[1:4] !smp_valid;
   endproperty
   a_pd: assert property (p_pd) else $error("pin did not power down");
   property p_nopd;
      calm && !ddc_en && sync_en && powerdown_or_align_pin |=> smp_valid [*4];
   endproperty
   a_nopd: assert property (p_nopd) else $error("align pin stopped stream");
endmodule : ddcnd_link_asserts
`default_nettype wire

// *** tb/ddc_nco_decimator_tb_top.sv ***
// testbench: apb controller end joined to converter end over the link
// assumes: core_clk is the sampling clock, adc_data driven by the bench
`timescale 1ns/1ns
`default_nettype none
module ddc_nco_decimator_tb_top;
   localparam logic [5:0] EN = 6'h01;
   localparam logic [5:0] RL = 6'h02;
   localparam logic [5:0] GN = 6'h04;
   localparam logic [5:0] F4 = 6'h08;
   localparam logic [5:0] SE = 6'h20;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [ddcnd_pkg::ADC_W-1:0] adc_data = '0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ddcnd_pkg::AW-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pd_active;
   int n_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   int n_pd = 0;
   ddcnd_link_if link ();
   ddcnd_device u_ddcnd_device (.core_clk(core_clk), .sys_rst(sys_rst), .link(link), .adc_data(adc_data),
      .pd_active(pd_active));
   ddcnd_host u_ddcnd_host (.core_clk(core_clk), .sys_rst(sys_rst), .link(link), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   ddcnd_link_asserts u_ddcnd_link_asserts (.core_clk(core_clk), .sys_rst(sys_rst), .ddc_en(link.ddc_en),
      .real_mode(link.real_mode), .gain_en(link.gain_en), .fs4_en(link.fs4_en), .phase_inv(link.phase_inv),
      .sync_en(link.sync_en), .nco_reload(link.nco_reload), .powerdown_or_align_pin(link.powerdown_or_align_pin),
      .dec_sel(link.dec_sel), .nco_word(link.nco_word), .smp_i(link.smp_i), .smp_q(link.smp_q),
      .smp_valid(link.smp_valid), .smp_real(link.smp_real));

   always #5 core_clk = ~core_clk;

   task automatic stop_test();
      if (n_errors == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (pd_active === 1'b1) n_pd <= n_pd + 1;
      if (cyc == 20000) begin
         n_errors = n_errors + 1;
         $display("[FAIL] %0t timeout", $time);
         stop_test();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   // called just after a rising edge; an idle cycle follows every transfer
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd, output logic [31:0] rd,
      output logic err);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      check({31'h0, pready}, 32'h0000_0001);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask : apb

   task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
      logic [31:0] rd;
      logic err;
      apb(1'b1, addr, wd, rd, err);
   endtask : wr

   task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
      logic [31:0] rd;
      logic err;
      apb(1'b0, addr, 32'h0000_0000, rd, err);
      check(rd, exp);
   endtask : rd_chk

   // off then on, so that enabling raises a fresh alignment request
   task automatic mode(input logic [5:0] bits, input logic [2:0] sel);
      wr(ddcnd_pkg::OFS_CTRL, {21'h0, sel, 2'h0, 6'h00});
      wr(ddcnd_pkg::OFS_CTRL, {21'h0, sel, 2'h0, bits});
      repeat (200) @(posedge core_clk);
   endtask : mode

   task automatic watch(input int ncyc, output int nv, output int nr, output int nq);
      nv = 0;
      nr = 0;
      nq = 0;
      repeat (ncyc) begin
         @(posedge core_clk);
         if (link.smp_valid === 1'b1) begin
            nv++;
            if (link.smp_real === 1'b1) nr++;
            if (link.smp_q === '0) nq++;
         end
      end
   endtask : watch

   initial begin
      int nv;
      int nr;
      int nq;
      int n;
      logic [31:0] rd;
      logic err;
      logic tog;
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      rd_chk(ddcnd_pkg::OFS_CTRL, 32'h0000_0000);
      rd_chk(ddcnd_pkg::OFS_CMD, 32'h0000_0000);
      apb(1'b0, 8'h18, 32'h0000_0000, rd, err);
      check(rd, 32'h0000_0000);
      check({31'h0, err}, 32'h0000_0001);
      adc_data <= 14'h2000;
      watch(32, nv, nr, nq);
      check(32'(nv), 32'h0000_0020);
      check(32'(nr), 32'h0000_0020);
      check({12'h000, link.smp_i}, 32'h0008_0000);
      rd_chk(ddcnd_pkg::OFS_LAST_I, 32'hfff8_0000);
      adc_data <= 14'h0100;
      for (int s = 0; s < 6; s++) begin
         mode(EN | SE, 3'(s));
         watch(320, nv, nr, nq);
         check(32'(nv), 32'(320 >> ((s > 4 ? 4 : s) + 1)));
         check(32'(nr), 32'h0000_0000);
      end
      wr(ddcnd_pkg::OFS_NCO, 32'h1234_5678);
      mode(EN | RL | SE, 3'h1);
      check(link.nco_word, 32'h0000_0000);
      watch(320, nv, nr, nq);
      check(32'(nv), 32'h0000_0050);
      check(32'(nr), 32'h0000_0050);
      check(32'(nq), 32'h0000_0050);
      rd_chk(ddcnd_pkg::OFS_LAST_I, 32'h0000_4000);
      mode(EN | RL | GN | SE, 3'h1);
      rd_chk(ddcnd_pkg::OFS_LAST_I, 32'h0000_5a00);
      wr(ddcnd_pkg::OFS_NCO, 32'h0000_0000);
      mode(EN | SE, 3'h1);
      rd_chk(ddcnd_pkg::OFS_LAST_I, 32'h0000_3ff8);
      rd_chk(ddcnd_pkg::OFS_LAST_Q, 32'h0000_0000);
      mode(EN | GN | SE, 3'h1);
      rd_chk(ddcnd_pkg::OFS_LAST_I, 32'h0000_7ff0);
      adc_data <= 14'h1fff;
      repeat (100) @(posedge core_clk);
      rd_chk(ddcnd_pkg::OFS_LAST_I, 32'h0007_ffff);
      // quarter-turn word: pairwise averaging cancels once it is live
      adc_data <= 14'h0100;
      wr(ddcnd_pkg::OFS_NCO, 32'h4000_0000);
      check(link.nco_word, 32'h4000_0000);
      repeat (100) @(posedge core_clk);
      rd_chk(ddcnd_pkg::OFS_LAST_I, 32'h0000_7ff0);
      tog = link.nco_reload;
      wr(ddcnd_pkg::OFS_CMD, 32'h0000_0001);
      check({31'h0, link.nco_reload}, {31'h0, ~tog});
      repeat (100) @(posedge core_clk);
      rd_chk(ddcnd_pkg::OFS_LAST_I, 32'h0000_0000);
      wr(ddcnd_pkg::OFS_NCO, 32'h0000_0000);
      wr(ddcnd_pkg::OFS_CMD, 32'h0000_0002);
      n = 0;
      while (link.powerdown_or_align_pin !== 1'b1 && n < 200) begin
         @(posedge core_clk);
         n++;
      end
      check(32'(n < 200), 32'h0000_0001);
      repeat (100) @(posedge core_clk);
      rd_chk(ddcnd_pkg::OFS_LAST_I, 32'h0000_7ff0);
      mode(EN | F4 | SE, 3'h2);
      watch(320, nv, nr, nq);
      check(32'(nv), 32'h0000_0050);
      check(32'(nr), 32'h0000_0050);
      wr(ddcnd_pkg::OFS_CTRL, {26'h0, SE});
      // let the checker settle so the pin pulse is judged
      repeat (70) @(posedge core_clk);
      wr(ddcnd_pkg::OFS_CMD, 32'h0000_0002);
      watch(128, nv, nr, nq);
      check(32'(nv), 32'h0000_0080);
      apb(1'b0, ddcnd_pkg::OFS_STAT, 32'h0000_0000, rd, err);
      check(rd & 32'h0000_0003, 32'h0000_0002);
      wr(ddcnd_pkg::OFS_CTRL, 32'h0000_0000);
      repeat (70) @(posedge core_clk);
      wr(ddcnd_pkg::OFS_CMD, 32'h0000_0002);
      watch(128, nv, nr, nq);
      check(32'(nv), 32'h0000_007f);
      check(32'(n_pd), 32'h0000_0001);
      stop_test();
   end
endmodule : ddc_nco_decimator_tb_top
`default_nettype wire
